// ==== core/asq_defs.svh ====
// register map, field positions and reset values of the conversion sequencer
// Notes on behaviour
// - start_channel_one bit 2 converts channel one
// - start_channel_two bit 1 converts channel two
// - start_temperature bit 0 converts temperature sensor
// - cpu halted from launch until conversion done
// - hardware clears the launching start bit
// - selector zero, channel one wins, differential
// - selector zero, channel two beats temperature
// - selector zero, temperature alone converts sensor
// - nonzero selector single-ended, channel one first
// - source selector lives in bits 11..8
// - result registers 01h 04h 07h read-only
// - setup_b resets 0070h, others 0000h
// - ten registers decoded at 00h..09h
// - control port bit15 go, bit14 read
// - low eight address bits decoded, port kept
// - data port kept on write, loaded on read
`ifndef ASQ_DEFS_SVH
`define ASQ_DEFS_SVH

`define ASQ_ADDR_CONTROL      8'h00
`define ASQ_ADDR_RESULT_ONE   8'h01
`define ASQ_ADDR_ONE_SETUP_A  8'h02
`define ASQ_ADDR_ONE_SETUP_B  8'h03
`define ASQ_ADDR_RESULT_TWO   8'h04
`define ASQ_ADDR_TWO_SETUP_A  8'h05
`define ASQ_ADDR_TWO_SETUP_B  8'h06
`define ASQ_ADDR_RESULT_TEMP  8'h07
`define ASQ_ADDR_TEMP_SETUP_A 8'h08
`define ASQ_ADDR_TEMP_SETUP_B 8'h09
`define ASQ_ADDR_LAST         8'h09

`define ASQ_RESET_CONTROL     16'h0000
`define ASQ_RESET_RESULT      16'h0000
`define ASQ_RESET_SETUP_A     16'h0000
`define ASQ_RESET_SETUP_B     16'h0070

`define ASQ_START_TEMP_BIT    0
`define ASQ_START_TWO_BIT     1
`define ASQ_START_ONE_BIT     2
`define ASQ_SE_LSB            8
`define ASQ_SE_MSB            11
`define ASQ_CONTROL_WMASK     16'h0f07
`define ASQ_SE_DIFFERENTIAL   4'h0

`define ASQ_GO_BIT            15
`define ASQ_READ_BIT          14
`define ASQ_ADDR_DECODE_MSB   7

`define ASQ_PORT_DATA         4'hd
`define ASQ_PORT_ADDR         4'he
`define ASQ_PORT_CTRL         4'hf

`endif

// ==== core/asq_pkg.sv ====
// types shared by the conversion sequencer modules
package asq_pkg;

	typedef enum logic {
		ASQ_IDLE,
		ASQ_BUSY
	} asq_state_t;

	// value doubles as the index into the per-channel register arrays
	typedef enum logic [1:0] {
		ASQ_CH_ONE,
		ASQ_CH_TWO,
		ASQ_CH_TEMP,
		ASQ_CH_NONE
	} asq_chan_t;

	typedef struct packed {
		asq_state_t        state;
		asq_chan_t         chan;
		logic [15:0]       control;
		logic [2:0][15:0]  result;
		logic [2:0][15:0]  setup_a;
		logic [2:0][15:0]  setup_b;
		logic [15:0]       data_port;
		logic [15:0]       addr_port;
		logic [15:0]       ctrl_port;
		logic              halt;
		logic              conv_start;
		logic [3:0]        conv_source;
		logic [15:0]       conv_setup_a;
		logic [15:0]       conv_setup_b;
	} asq_regs_t;

endpackage : asq_pkg

// ==== core/asq_access_decode.sv ====
// decodes a pending indirect module access from the address and control ports
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.svh"

module asq_access_decode
	import asq_pkg::*;
(
	// cpu ports
	input  wire logic [15:0] ctrl_port,
	input  wire logic [15:0] addr_port,
	input  wire logic        halted,
	// decoded access
	output logic             acc_go,
	output logic             acc_read,
	output logic             acc_write,
	output logic             acc_hit,
	output logic [7:0]       acc_index
);

	// upper address byte deliberately ignored
	assign acc_index = addr_port[`ASQ_ADDR_DECODE_MSB:0];
	assign acc_hit   = (acc_index <= `ASQ_ADDR_LAST);
	// no access while halted: a go the cpu writes in the launching cycle waits for release
	assign acc_go    = ctrl_port[`ASQ_GO_BIT] && !halted;
	assign acc_read  = acc_go && ctrl_port[`ASQ_READ_BIT];
	assign acc_write = acc_go && !ctrl_port[`ASQ_READ_BIT];

endmodule : asq_access_decode
`default_nettype wire

// ==== core/asq_start_arbiter.sv ====
// fixed priority among the three start bits
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.svh"

module asq_start_arbiter
	import asq_pkg::*;
(
	// request
	input  wire logic [2:0] start_bits,
	input  wire logic [3:0] source_sel,
	// decision
	output logic            launch,
	output asq_chan_t       chan,
	output logic [2:0]      drop_mask
);

	always_comb
	begin
		launch    = 1'b0;
		chan      = ASQ_CH_NONE;
		drop_mask = 3'h0;
		if (start_bits[`ASQ_START_ONE_BIT])
		begin
			launch = 1'b1;
			chan   = ASQ_CH_ONE;
		end
		else if (start_bits[`ASQ_START_TWO_BIT])
		begin
			launch = 1'b1;
			chan   = ASQ_CH_TWO;
		end
		else if (start_bits[`ASQ_START_TEMP_BIT])
		begin
			if (source_sel == `ASQ_SE_DIFFERENTIAL)
			begin
				launch = 1'b1;
				chan   = ASQ_CH_TEMP;
			end
			else
			begin
				// undefined request: dropped so the cpu is never stuck
				drop_mask = 3'h1;
			end
		end
	end

endmodule : asq_start_arbiter
`default_nettype wire

// ==== core/asq_sequencer.sv ====
// conversion sequencer: module ports, adc register file and conversion control
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.svh"

module asq_sequencer
	import asq_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// cpu port writes
	input  wire logic        cpu_port_wr,
	input  wire logic [3:0]  cpu_port_addr,
	input  wire logic [15:0] cpu_port_wdata,
	// cpu port contents and stall
	output logic [15:0]      module_data_port,
	output logic [15:0]      module_address_port,
	output logic [15:0]      module_control_port,
	output logic             cpu_halt,
	// analog converter
	output logic             conv_start,
	output logic [1:0]       conv_channel,
	output logic [3:0]       single_ended_source_select,
	output logic [15:0]      conv_setup_a,
	output logic [15:0]      conv_setup_b,
	input  wire logic        conv_done,
	input  wire logic [15:0] conv_result
);

	asq_regs_t   q;
	asq_regs_t   d;

	logic        acc_go;
	logic        acc_read;
	logic        acc_write;
	logic        acc_hit;
	logic [7:0]  acc_index;
	logic        arb_launch;
	asq_chan_t   arb_chan;
	logic [2:0]  arb_drop;
	logic [15:0] control_wval;
	logic [15:0] read_value;

	asq_access_decode u_decode (
		.ctrl_port (q.ctrl_port),
		.addr_port (q.addr_port),
		.halted    (q.halt),
		.acc_go    (acc_go),
		.acc_read  (acc_read),
		.acc_write (acc_write),
		.acc_hit   (acc_hit),
		.acc_index (acc_index)
	);

	// only writable control bits are kept; unused bits read zero
	assign control_wval = q.data_port & `ASQ_CONTROL_WMASK;

	asq_start_arbiter u_arbiter (
		.start_bits (control_wval[`ASQ_START_ONE_BIT:`ASQ_START_TEMP_BIT]),
		.source_sel (control_wval[`ASQ_SE_MSB:`ASQ_SE_LSB]),
		.launch     (arb_launch),
		.chan       (arb_chan),
		.drop_mask  (arb_drop)
	);

	// register read mux
	always_comb
	begin
		read_value = 16'h0000;
		if (acc_index == `ASQ_ADDR_CONTROL)
			read_value = q.control;
		else if (acc_index == `ASQ_ADDR_RESULT_ONE)
			read_value = q.result[ASQ_CH_ONE];
		else if (acc_index == `ASQ_ADDR_ONE_SETUP_A)
			read_value = q.setup_a[ASQ_CH_ONE];
		else if (acc_index == `ASQ_ADDR_ONE_SETUP_B)
			read_value = q.setup_b[ASQ_CH_ONE];
		else if (acc_index == `ASQ_ADDR_RESULT_TWO)
			read_value = q.result[ASQ_CH_TWO];
		else if (acc_index == `ASQ_ADDR_TWO_SETUP_A)
			read_value = q.setup_a[ASQ_CH_TWO];
		else if (acc_index == `ASQ_ADDR_TWO_SETUP_B)
			read_value = q.setup_b[ASQ_CH_TWO];
		else if (acc_index == `ASQ_ADDR_RESULT_TEMP)
			read_value = q.result[ASQ_CH_TEMP];
		else if (acc_index == `ASQ_ADDR_TEMP_SETUP_A)
			read_value = q.setup_a[ASQ_CH_TEMP];
		else if (acc_index == `ASQ_ADDR_TEMP_SETUP_B)
			read_value = q.setup_b[ASQ_CH_TEMP];
	end

	always_comb
	begin
		d            = q;
		d.conv_start = 1'b0;

		// module access, one cycle after the go bit is seen
		if (acc_write && acc_hit)
		begin
			// data port is left as it was on writes
			if (acc_index == `ASQ_ADDR_CONTROL)
				d.control = control_wval & ~{13'h0000, arb_drop};
			else if (acc_index == `ASQ_ADDR_ONE_SETUP_A)
				d.setup_a[ASQ_CH_ONE] = q.data_port;
			else if (acc_index == `ASQ_ADDR_ONE_SETUP_B)
				d.setup_b[ASQ_CH_ONE] = q.data_port;
			else if (acc_index == `ASQ_ADDR_TWO_SETUP_A)
				d.setup_a[ASQ_CH_TWO] = q.data_port;
			else if (acc_index == `ASQ_ADDR_TWO_SETUP_B)
				d.setup_b[ASQ_CH_TWO] = q.data_port;
			else if (acc_index == `ASQ_ADDR_TEMP_SETUP_A)
				d.setup_a[ASQ_CH_TEMP] = q.data_port;
			else if (acc_index == `ASQ_ADDR_TEMP_SETUP_B)
				d.setup_b[ASQ_CH_TEMP] = q.data_port;
			// result addresses fall through: writes ignored
		end
		if (acc_read)
		begin
			// unmapped reads return zero
			d.data_port = acc_hit ? read_value : 16'h0000;
		end
		if (acc_go)
		begin
			d.ctrl_port[`ASQ_GO_BIT] = 1'b0;
		end

		// launch happens on the same edge that stores the control word
		if (acc_write && acc_hit && (acc_index == `ASQ_ADDR_CONTROL) && arb_launch)
		begin
			d.state        = ASQ_BUSY;
			d.chan         = arb_chan;
			d.halt         = 1'b1;
			d.conv_start   = 1'b1;
			d.conv_source  = control_wval[`ASQ_SE_MSB:`ASQ_SE_LSB];
			d.conv_setup_a = q.setup_a[arb_chan];
			d.conv_setup_b = q.setup_b[arb_chan];
		end

		case (q.state)
			ASQ_IDLE:
			begin
				d.halt = d.halt;
			end
			ASQ_BUSY:
			begin
				if (conv_done)
				begin
					// store, clear and release together
					d.result[q.chan] = conv_result;
					if (q.chan == ASQ_CH_ONE)
						d.control[`ASQ_START_ONE_BIT] = 1'b0;
					else if (q.chan == ASQ_CH_TWO)
						d.control[`ASQ_START_TWO_BIT] = 1'b0;
					else
						d.control[`ASQ_START_TEMP_BIT] = 1'b0;
					d.halt  = 1'b0;
					d.state = ASQ_IDLE;
					d.chan  = ASQ_CH_NONE;
				end
			end
			default:
			begin
				d.state = ASQ_IDLE;
			end
		endcase

		// cpu writes to its ports; a halted cpu executes nothing
		if (cpu_port_wr && !q.halt)
		begin
			if (cpu_port_addr == `ASQ_PORT_DATA)
				d.data_port = cpu_port_wdata;
			else if (cpu_port_addr == `ASQ_PORT_ADDR)
				d.addr_port = cpu_port_wdata;
			else if (cpu_port_addr == `ASQ_PORT_CTRL)
				d.ctrl_port = cpu_port_wdata;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			q         <= '0;
			q.state   <= ASQ_IDLE;
			q.chan    <= ASQ_CH_NONE;
			q.control <= `ASQ_RESET_CONTROL;
			q.result  <= {3{`ASQ_RESET_RESULT}};
			q.setup_a <= {3{`ASQ_RESET_SETUP_A}};
			q.setup_b <= {3{`ASQ_RESET_SETUP_B}};
		end
		else
		begin
			q <= d;
		end
	end

	assign module_data_port           = q.data_port;
	assign module_address_port        = q.addr_port;
	assign module_control_port        = q.ctrl_port;
	assign cpu_halt                   = q.halt;
	assign conv_start                 = q.conv_start;
	assign conv_channel               = q.chan;
	assign single_ended_source_select = q.conv_source;
	assign conv_setup_a               = q.conv_setup_a;
	assign conv_setup_b               = q.conv_setup_b;

endmodule : asq_sequencer
`default_nettype wire

// ==== testbench/asq_sequencer_properties.sv ====
// port assertions of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer_properties (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// cpu side
	input wire logic        cpu_port_wr,
	input wire logic [3:0]  cpu_port_addr,
	input wire logic [15:0] cpu_port_wdata,
	input wire logic [15:0] module_data_port,
	input wire logic [15:0] module_address_port,
	input wire logic [15:0] module_control_port,
	input wire logic        cpu_halt,
	// converter side
	input wire logic        conv_start,
	input wire logic [1:0]  conv_channel,
	input wire logic [3:0]  single_ended_source_select,
	input wire logic        conv_done
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// an access launched, not overwritten by the cpu in the executing cycle
	sequence s_go;
		cpu_port_wr && cpu_port_addr == 4'hf && cpu_port_wdata[15] && !cpu_halt
			##1 !(cpu_port_wr && cpu_port_addr == 4'hf) && !cpu_halt;
	endsequence
	sequence s_wgo;
		cpu_port_wr && cpu_port_addr == 4'hf && cpu_port_wdata[15:14] == 2'b10 && !cpu_halt
			##1 !(cpu_port_wr && cpu_port_addr == 4'hd);
	endsequence
	a_start_halts: assert property (conv_start |-> cpu_halt) else $error("start without halt");
	a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start too long");
	a_halt_holds: assert property (cpu_halt && !conv_done |=> cpu_halt) else $error("halt dropped");
	a_done_release: assert property (cpu_halt && conv_done
		|=> !cpu_halt && conv_channel == 2'd3) else $error("done did not release");
	a_launch_channel: assert property ($rose(cpu_halt) |-> conv_start && conv_channel != 2'd3)
		else $error("halt without launch");
	a_temp_differential: assert property (conv_start && conv_channel == 2'd2
		|-> single_ended_source_select == 4'h0) else $error("temp with source");
	a_go_clears: assert property (s_go |=> !module_control_port[15]) else $error("go kept");
	a_addr_kept: assert property (!(cpu_port_wr && cpu_port_addr == 4'he)
		|=> $stable(module_address_port)) else $error("address port moved");
	a_data_kept: assert property (s_wgo |=> $stable(module_data_port)) else $error("data moved");
endmodule : asq_sequencer_properties
bind asq_sequencer asq_sequencer_properties u_props (.mclk, .reset, .cpu_port_wr, .cpu_port_addr,
	.cpu_port_wdata, .module_data_port, .module_address_port, .module_control_port, .cpu_halt,
	.conv_start, .conv_channel, .single_ended_source_select, .conv_done);
`default_nettype wire

// ==== testbench/asq_adc_model.sv ====
// behavioural analog converter answering the start pulse
`timescale 1ns/1ps
`default_nettype none
module asq_adc_model (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// from the sequencer
	input wire logic        conv_start,
	// bench settings
	input wire logic [3:0]  lat,
	input wire logic [15:0] value,
	// answer
	output logic            conv_done,
	output logic [15:0]     conv_result
);
	logic [3:0] cnt_q;
	always_ff @(posedge mclk)
	begin
		if (reset)
			cnt_q <= 4'h0;
		else if (conv_start)
			cnt_q <= lat;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	assign conv_done = cnt_q == 4'h1;
	// inverse outside done so a stale sample is never taken as valid
	assign conv_result = conv_done ? value : ~value;
endmodule : asq_adc_model
`default_nettype wire

// ==== testbench/adc_conversion_sequencer_bench.sv ====
// self-checking bench of the conversion sequencer against a register model
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, g, n) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module adc_conversion_sequencer_bench;
	logic        mclk = 1'b0, reset = 1'b1, cpu_port_wr = 1'b0;
	logic [3:0]  cpu_port_addr = 4'h0, lat = 4'h1, sel;
	logic [15:0] cpu_port_wdata = 16'h0000, value = 16'h0000, v, m[10];
	logic [15:0] module_data_port, module_address_port, module_control_port;
	logic [15:0] conv_setup_a, conv_setup_b, conv_result;
	logic        cpu_halt, conv_start, conv_done;
	logic [1:0]  conv_channel;
	logic [3:0]  single_ended_source_select;
	logic [2:0]  bits;
	logic [31:0] seed = 32'h81a6;
	int          bad_count = 0, compares = 0, ch;
	always #5 mclk = ~mclk;
	asq_sequencer u_asq_sequencer (.mclk, .reset, .cpu_port_wr, .cpu_port_addr, .cpu_port_wdata,
		.module_data_port, .module_address_port, .module_control_port, .cpu_halt, .conv_start,
		.conv_channel, .single_ended_source_select, .conv_setup_a, .conv_setup_b, .conv_done,
		.conv_result);
	asq_adc_model u_asq_adc_model (.mclk, .reset, .conv_start, .lat, .value, .conv_done,
		.conv_result);
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	task automatic pw(input logic [3:0] a, input logic [15:0] d);
		@(negedge mclk);
		cpu_port_wr = 1'b1;
		cpu_port_addr = a;
		cpu_port_wdata = d;
		@(negedge mclk);
		cpu_port_wr = 1'b0;
	endtask : pw
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		pw(4'he, a);
		pw(4'hd, d);
		pw(4'hf, 16'h8000);
		@(negedge mclk);
		`CHK(d, module_data_port, "data port")
		`CHK(a, module_address_port, "address port")
		`CHK(16'h0000, module_control_port, "control port")
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		pw(4'he, a);
		pw(4'hf, 16'hc000);
		@(negedge mclk);
		`CHK(e, module_data_port, "read data")
		`CHK(16'h4000, module_control_port, "go cleared")
	endtask : rd
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		conclude();
	end
	initial
	begin
		for (int i = 0; i < 10; i++)
			m[i] = (i % 3 == 0 && i > 0) ? 16'h0070 : 16'h0000;
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		for (int i = 0; i < 12; i++)
			rd(i < 10 ? 16'(i) : (i == 10 ? 16'h000a : 16'h5503), i < 10 ? m[i] :
				(i == 10 ? 16'h0000 : m[3]));
		$display("test reset values done");
		for (int i = 0; i < 10; i++)
		begin
			v = i == 0 ? (rnd() & 16'h0f00) : rnd();
			wr(16'(i), v);
			if (i % 3 != 1)
				m[i] = v;
		end
		for (int i = 0; i < 11; i++)
			rd(16'(i), i < 10 ? m[i] : 16'h0000);
		$display("test register access done");
		for (int k = 1; k < 15; k++)
		begin
			bits = 3'(k > 7 ? k - 7 : k);
			sel = k > 7 ? 4'(rnd() % 15 + 1) : 4'h0;
			ch = bits[2] ? 0 : bits[1] ? 1 : sel == 4'h0 ? 2 : 3; // only k=8 breaks it
			value = rnd();
			lat = 4'(rnd() % 8 + 1);
			wr(16'h0000, {4'h0, sel, 5'h00, bits});
			`CHK(ch != 3, cpu_halt, "halt")
			`CHK(ch != 3, conv_start, "start")
			if (ch != 3)
			begin
				`CHK(2'(ch), conv_channel, "channel")
				`CHK(m[ch * 3 + 2], conv_setup_a, "setup a")
				`CHK(m[ch * 3 + 3], conv_setup_b, "setup b")
				`CHK(sel, single_ended_source_select, "source")
				pw(4'hd, 16'hffff);
				`CHK(({4'h0, sel, 5'h00, bits}), module_data_port, "halted write")
				for (int w = 0; w < 40 && cpu_halt; w++)
					@(negedge mclk);
				`CHK(1'b0, cpu_halt, "release")
				m[ch * 3 + 1] = value;
				bits[2 - ch] = 1'b0;
				rd(16'(ch * 3 + 1), m[ch * 3 + 1]);
			end
			else
				bits[0] = 1'b0;
			rd(16'h0000, {4'h0, sel, 5'h00, bits});
		end
		$display("test conversions done");
		conclude();
	end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
